// ### rtl/usr_cfg.svh
`ifndef USR_CFG_SVH
`define USR_CFG_SVH
// Oversampling per bit and the first of the three voting samples.
`define USR_OS_NORM 5'h10
`define USR_OS_DBL 5'h08
`define USR_VOTE_NORM 5'h08
`define USR_VOTE_DBL 5'h04
// Frame layout: start is bit 0, data bits 1..8, stop is bit 9.
`define USR_DATA_BITS 4'h8
`define USR_LAST_DATA 4'h7
`define USR_STOP_IDX 4'h9
// Index of the last of the sixteen transfer clock half periods in one synchronous frame.
`define USR_LAST_HALF 5'h0F
// Line-driver mode field encodings.
`define USR_LDM_OFF 2'h0
`define USR_LDM_EXT 2'h1
`define USR_LDM_TXD 2'h2
// Sleep state encoding at SLEEP_MODE_I.
`define USR_SLP_STANDBY 2'h2
// Reset values.
`define USR_BAUD_RST 16'h0000
`define USR_BYTE_RST 8'h00
// Receiver tolerance at eight data-plus-parity bits, in 0.01 percent.
`define USR_TOL_NORM_SLOW 9536
`define USR_TOL_NORM_FAST 10458
`define USR_TOL_DBL_SLOW 9600
`define USR_TOL_DBL_FAST 10390
`define USR_TOL_SIDE_ERR 200
`endif

// ### rtl/usr_pkg.sv
package usr_pkg;
  typedef struct packed {
    logic tx_enable;
    logic rx_enable;
    logic sync_mode;
    logic double_speed_select;
    logic sync_phase_select;
    logic sync_bit_order_select;
    logic [1:0] line_driver_mode;
    logic start_detect_enable;
    logic rxc_int_enable;
    logic start_int_enable;
    logic [15:0] baud_div;
  } usr_cfg_t;
  typedef struct packed {
    logic tx_write;
    logic [7:0] tx_data;
    logic rx_read;
    logic txc_clear;
    logic start_clear;
  } usr_ctl_t;
  typedef struct packed {
    logic dre;
    logic txc;
    logic receive_complete_flag;
    logic start_detected_flag;
    logic frame_error;
    logic [7:0] rx_data;
  } usr_stat_t;
  typedef enum logic [1:0] {T_IDLE, T_GUARD, T_ASYNC, T_SYNC} usr_tx_st_t;
  typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} usr_rx_st_t;
endpackage

// ### rtl/usr_serial.sv
`timescale 1ns/1ps
`include "usr_cfg.svh"
module usr_serial (
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic LINK_CLK_I,
  input wire usr_pkg::usr_cfg_t CFG_I,
  input wire usr_pkg::usr_ctl_t CTL_I,
  input wire logic [1:0] SLEEP_MODE_I,
  input wire logic RXD_I,
  output logic TXD_O,
  output logic TXD_OE_O,
  output logic TRANSFER_CLOCK_PIN_O,
  output logic TRANSFER_CLOCK_PIN_OE_O,
  output logic LINE_DRIVER_ENABLE_OUT_O,
  output usr_pkg::usr_stat_t STAT_O,
  output logic RX_IRQ_O,
  output logic PORT_CLK_REQ_O
);
  import usr_pkg::*;

  logic [15:0] bcnt;
  logic tick, rxd1, rxd_s, rxd_d;
  logic [4:0] os, osm1, vote, vote_end, rsmp, tsmp, thc;
  usr_rx_st_t rstate;
  usr_tx_st_t tstate;
  logic [3:0] rbit, tbit;
  logic [1:0] rvote;
  logic [7:0] rsh, sh, ssh, next_ssh, tx_buf, rx_data;
  logic maj, decide, rx_fin, rx_rej, sync_fin, tdone, tx_load, write_ok;
  logic tx_full, txo, transfer_clock_pin, txc, rxc, ferr, sdf, te, lsb, arm;
  logic lrst1, lrst2, la1, la2, lr1, lr2, lr3, req, k1, k2, k3;
  logic w1, w2, w3, ack_t, ackd, sdf_set;

  // Baud generator; one tick is one sample (async) or half clock (sync).
  // Faster synchronous clocks come only from a smaller divider.
  assign tick = (bcnt == CFG_I.baud_div);
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I || tick) begin
      bcnt <= `USR_BAUD_RST;
    end else begin
      bcnt <= bcnt + 16'h0001;
    end
  end

  // Pin synchroniser; the second stage and the third stage behind it feed logic.
  always_ff @(posedge REF_CLK_I) begin
    rxd1 <= RXD_I;
    rxd_s <= rxd1;
    rxd_d <= rxd_s;
  end

  // Sampling geometry follows the speed select.
  assign os = CFG_I.double_speed_select ? `USR_OS_DBL : `USR_OS_NORM;
  assign osm1 = os - 5'h01;
  assign vote = CFG_I.double_speed_select ? `USR_VOTE_DBL : `USR_VOTE_NORM;
  assign vote_end = vote + 5'h02;
  assign maj = (rvote[1] & rvote[0]) | (rvote[1] & rxd_s) |
               (rvote[0] & rxd_s);
  assign decide = tick && (rstate != R_IDLE) && (rsmp == vote_end);
  assign rx_fin = decide && (rstate == R_STOP);
  assign rx_rej = decide && (rstate == R_START) && maj;

  // Asynchronous receiver with three-sample majority voting. Deciding on
  // the centre samples and freeing the line right after the stop vote
  // gives the tolerated rate window at either speed.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      rstate <= R_IDLE;
      rsmp <= 5'h00;
      rbit <= 4'h0;
      rvote <= 2'b00;
      rsh <= `USR_BYTE_RST;
    end else if (!CFG_I.rx_enable || CFG_I.sync_mode) begin
      rstate <= R_IDLE;
    end else if (tick) begin
      if (rstate == R_IDLE) begin
        if (rxd_d && !rxd_s) begin
          rstate <= R_START;
          rsmp <= 5'h02;
        end
      end else begin
        rsmp <= (rsmp == os) ? 5'h01 : rsmp + 5'h01;
        if (rsmp == vote || rsmp == vote + 5'h01) begin
          rvote <= {rvote[0], rxd_s};
        end
        if (rsmp == vote_end) begin
          case (rstate)
            R_START: begin
              rstate <= maj ? R_IDLE : R_DATA;
              rbit <= 4'h0;
            end
            R_DATA: begin
              rsh <= {maj, rsh[7:1]};
              rbit <= rbit + 4'h1;
              if (rbit == `USR_LAST_DATA) begin
                rstate <= R_STOP;
              end
            end
            default: rstate <= R_IDLE;
          endcase
        end
      end
    end
  end

  // Transmit buffer; writes are taken only while it is empty and the
  // transmitter is on, so there is no collision to detect.
  assign write_ok = CTL_I.tx_write && !tx_full && CFG_I.tx_enable;
  assign tdone = tick && (((tstate == T_ASYNC) && (tsmp == osm1) &&
                 (tbit == `USR_STOP_IDX)) ||
                 ((tstate == T_SYNC) && (thc == `USR_LAST_HALF)));
  // Pending data still drains after the transmitter is switched off.
  assign tx_load = tx_full && ((tstate == T_IDLE) || tdone);
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      tx_full <= 1'b0;
      tx_buf <= `USR_BYTE_RST;
    end else if (write_ok) begin
      tx_full <= 1'b1;
      tx_buf <= CTL_I.tx_data;
    end else if (tx_load) begin
      tx_full <= 1'b0;
    end
  end

  // Bit order select: set means least significant bit first.
  assign lsb = CFG_I.sync_bit_order_select;
  assign next_ssh = lsb ? {rxd_s, ssh[7:1]} : {ssh[6:0], rxd_s};
  assign sync_fin = tdone && (tstate == T_SYNC) && CFG_I.rx_enable;

  // Transmit engine. The guard state holds the driver enable for one bit
  // before the start bit; back-to-back frames skip it since the enable
  // never drops. Synchronous frames toggle the transfer clock per tick.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      tstate <= T_IDLE;
      tsmp <= 5'h00;
      tbit <= 4'h0;
      thc <= 5'h00;
      sh <= `USR_BYTE_RST;
      ssh <= `USR_BYTE_RST;
      txo <= 1'b1;
      transfer_clock_pin <= 1'b0;
    end else if (tx_load) begin
      tsmp <= 5'h00;
      tbit <= 4'h0;
      thc <= 5'h00;
      transfer_clock_pin <= 1'b0;
      if (CFG_I.sync_mode) begin
        tstate <= T_SYNC;
        if (!CFG_I.sync_phase_select) begin
          txo <= lsb ? tx_buf[0] : tx_buf[7];
          sh <= lsb ? {1'b0, tx_buf[7:1]} : {tx_buf[6:0], 1'b0};
        end else begin
          sh <= tx_buf;
        end
      end else if (CFG_I.line_driver_mode != `USR_LDM_OFF &&
                   tstate == T_IDLE) begin
        tstate <= T_GUARD;
        sh <= tx_buf;
        txo <= 1'b1;
      end else begin
        tstate <= T_ASYNC;
        sh <= tx_buf;
        txo <= 1'b0;
      end
    end else if (tick) begin
      case (tstate)
        T_GUARD: begin
          tsmp <= (tsmp == osm1) ? 5'h00 : tsmp + 5'h01;
          if (tsmp == osm1) begin
            tstate <= T_ASYNC;
            txo <= 1'b0;
          end
        end
        T_ASYNC: begin
          tsmp <= (tsmp == osm1) ? 5'h00 : tsmp + 5'h01;
          if (tsmp == osm1) begin
            tbit <= tbit + 4'h1;
            if (tbit == `USR_STOP_IDX) begin
              tstate <= T_IDLE;
              txo <= 1'b1;
            end else if (tbit == `USR_DATA_BITS) begin
              txo <= 1'b1;
            end else begin
              txo <= sh[0];
              sh <= {1'b0, sh[7:1]};
            end
          end
        end
        T_SYNC: begin
          thc <= thc + 5'h01;
          transfer_clock_pin <= ~transfer_clock_pin;
          // Leading edge samples with phase 0, trailing with phase 1.
          if (thc[0] == CFG_I.sync_phase_select) begin
            ssh <= next_ssh;
          end else begin
            txo <= lsb ? sh[0] : sh[7];
            sh <= lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
          end
          if (thc == `USR_LAST_HALF) begin
            tstate <= T_IDLE;
            transfer_clock_pin <= 1'b0;
            txo <= 1'b1;
          end
        end
        default: tstate <= T_IDLE;
      endcase
    end
  end

  // Receive data and flags; a new frame beats a same-cycle read.
  // Disabling the receiver flushes the buffer at once.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I || !CFG_I.rx_enable) begin
      rxc <= 1'b0;
      ferr <= 1'b0;
      rx_data <= `USR_BYTE_RST;
    end else if (rx_fin || sync_fin) begin
      rxc <= 1'b1;
      ferr <= rx_fin && !maj;
      rx_data <= CFG_I.sync_phase_select ? next_ssh : ssh;
      if (rx_fin) begin
        rx_data <= rsh;
      end
    end else if (CTL_I.rx_read) begin
      rxc <= 1'b0;
    end
  end

  // Transmit complete: frame out and nothing waiting; set beats clear.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      txc <= 1'b0;
    end else if (tdone && !tx_full) begin
      txc <= 1'b1;
    end else if (CTL_I.txc_clear) begin
      txc <= 1'b0;
    end
  end

  // Detection is armed only asynchronously and only in standby.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      arm <= 1'b0;
    end else begin
      arm <= CFG_I.start_detect_enable && !CFG_I.sync_mode &&
             (SLEEP_MODE_I == `USR_SLP_STANDBY);
    end
  end

  // Link-side reset and input synchronisers.
  always_ff @(posedge LINK_CLK_I) begin
    lrst1 <= NRST_I;
    lrst2 <= lrst1;
    la1 <= arm;
    la2 <= la1;
    lr1 <= RXD_I;
    lr2 <= lr1;
    lr3 <= lr2;
    k1 <= ack_t;
    k2 <= k1;
    k3 <= k2;
  end

  // Always-on detector: a falling edge while armed raises the clock
  // request; each acknowledge toggle drops it again.
  always_ff @(posedge LINK_CLK_I) begin
    if (!lrst2) begin
      req <= 1'b0;
    end else if (k2 ^ k3) begin
      req <= 1'b0;
    end else if (la2 && lr3 && !lr2) begin
      req <= 1'b1;
    end
  end
  assign PORT_CLK_REQ_O = req;

  // Request seen on the port clock side. The chain is cleared by reset
  // so an unknown request cannot fire a spurious acknowledge.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      w1 <= 1'b0;
      w2 <= 1'b0;
      w3 <= 1'b0;
    end else begin
      w1 <= req;
      w2 <= w1;
      w3 <= w2;
    end
  end

  // One acknowledge per request: after the frame or a false start, or
  // once the system has woken by other means and disarmed detection.
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      ack_t <= 1'b0;
      ackd <= 1'b0;
    end else if (!w2) begin
      ackd <= 1'b0;
    end else if (!ackd && (rx_fin || rx_rej || !arm)) begin
      ack_t <= ~ack_t;
      ackd <= 1'b1;
    end
  end

  // Start detected flag; set beats clear.
  assign sdf_set = w2 && !w3 && (SLEEP_MODE_I == `USR_SLP_STANDBY);
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      sdf <= 1'b0;
    end else if (sdf_set) begin
      sdf <= 1'b1;
    end else if (CTL_I.start_clear) begin
      sdf <= 1'b0;
    end
  end

  // Shared line; its enables choose which event wakes all clocks.
  assign RX_IRQ_O = (rxc && CFG_I.rxc_int_enable) ||
                    (sdf && CFG_I.start_int_enable);

  // Pin drive. Mode two hands the data pin to the transmitter only
  // while a frame is under way; otherwise it is held while enabled.
  assign te = (tstate != T_IDLE) && !CFG_I.sync_mode;
  assign LINE_DRIVER_ENABLE_OUT_O =
    te && (CFG_I.line_driver_mode != `USR_LDM_OFF);
  assign TXD_O = txo;
  assign TXD_OE_O = (CFG_I.line_driver_mode == `USR_LDM_TXD) ?
    te : (CFG_I.tx_enable || tstate != T_IDLE || tx_full);
  assign TRANSFER_CLOCK_PIN_O = transfer_clock_pin;
  assign TRANSFER_CLOCK_PIN_OE_O = CFG_I.sync_mode && CFG_I.tx_enable;
  assign STAT_O = '{dre: !tx_full, txc: txc, receive_complete_flag: rxc,
    start_detected_flag: sdf,
    frame_error: ferr && !CFG_I.sync_mode,
    rx_data: rx_data};

  a_te_guard: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    $rose(LINE_DRIVER_ENABLE_OUT_O) |-> TXD_O && tstate == T_GUARD)
    else $error("driver enable rose without guard bit");
  a_te_frame: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    $fell(TXD_O) && tstate == T_ASYNC &&
    CFG_I.line_driver_mode != `USR_LDM_OFF
    |-> LINE_DRIVER_ENABLE_OUT_O [*8])
    else $error("driver enable dropped inside frame");
  a_te_drop: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    $fell(LINE_DRIVER_ENABLE_OUT_O) && !$past(CFG_I.sync_mode)
    |-> TXD_O && !tx_full)
    else $error("driver enable fell mid frame");
  a_err_zero: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    CFG_I.sync_mode |-> !STAT_O.frame_error)
    else $error("error flag set in synchronous mode");
  a_load_ready: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    tx_load |=> tstate != T_IDLE && !tx_full)
    else $error("buffer not moved to shifter");
  a_sync_idle: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    CFG_I.sync_mode && !tx_full && tstate == T_IDLE |=> tstate == T_IDLE)
    else $error("transfer started without a write");
  a_sfd_gate: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    SLEEP_MODE_I != `USR_SLP_STANDBY |-> !sdf_set ##1 !arm)
    else $error("start detect active outside standby");
  a_irq_shared: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    (sdf && CFG_I.start_int_enable) || (rxc && CFG_I.rxc_int_enable)
    |-> RX_IRQ_O)
    else $error("shared interrupt line missing");
  a_xck_idle: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
    tstate != T_SYNC |-> !TRANSFER_CLOCK_PIN_O)
    else $error("transfer clock not idle low");
endmodule // usr_serial

// ### dv/usr_peer.sv
`timescale 1ns/1ps
module usr_peer (
  input wire logic sclk_i,
  input wire logic phase_i,
  input wire logic lsb_first_i,
  output logic rxd_o
);
  logic [7:0] miso_byte;
  int idx;

  // The line idles high and no synchronous byte is loaded at start.
  initial begin
    rxd_o = 1'b1;
    miso_byte = 8'h00;
    idx = 9;
  end

  function automatic logic bit_at(input int k);
    return lsb_first_i ? miso_byte[k] : miso_byte[7 - k];
  endfunction

  // Sends start, eight bits LSB first and one stop at its own bit time.
  // Callers stay within half the error budget, so the rest is the receiver's.
  task automatic send(input logic [7:0] b, input realtime bit_ns,
      input logic stop);
    // Keep the line off the sampling edge of the port clock.
    #5;
    rxd_o = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      rxd_o = b[i];
      #(bit_ns);
    end
    rxd_o = stop;
    #(bit_ns);
    rxd_o = 1'b1;
  endtask

  // A low pulse shorter than half a bit, which a receiver must reject.
  task automatic glitch(input realtime w);
    #5;
    rxd_o = 1'b0;
    #(w);
    rxd_o = 1'b1;
  endtask

  // Phase zero needs the first bit on the line before the first edge.
  task automatic load(input logic [7:0] b);
    miso_byte = b;
    idx = 0;
    if (!phase_i) rxd_o = bit_at(0);
  endtask

  // Phase one presents each bit on the rising edge of the shift clock.
  always @(posedge sclk_i) begin
    if (phase_i && idx < 8) begin
      rxd_o = bit_at(idx);
      idx++;
    end
  end

  // Phase zero shifts on the falling edge; once the hold time is over the
  // line shows the inverse of its last bit so a late sample cannot pass.
  always @(negedge sclk_i) begin
    if (!phase_i && idx < 8) begin
      idx++;
      rxd_o = (idx < 8) ? bit_at(idx) : ~rxd_o;
    end else if (phase_i && idx == 8) begin
      idx = 9;
      rxd_o = ~rxd_o;
    end
  end
endmodule // usr_peer

// ### dv/tb_usart_spi_line_driver_mode_startdetect.sv
`timescale 1ns/1ps
module tb_usart_spi_line_driver_mode_startdetect;
  import usr_pkg::*;
  typedef struct {logic dbl; realtime bt; logic [7:0] d; logic stp;} usr_row_t;
  localparam usr_ctl_t rd_p = '{rx_read: 1'b1, default: '0};
  localparam usr_ctl_t clr_p = '{rx_read: 1'b1, txc_clear: 1'b1,
      start_clear: 1'b1, default: '0};
  logic clk, lclk, nrst, rxd, txd, txd_oe, transfer_clock_pin, xck_oe, lde, irq, creq;
  logic hi, prv, ptx;
  logic [1:0] slp;
  logic [7:0] got;
  usr_cfg_t cfg;
  usr_ctl_t ctl;
  usr_stat_t st;
  int fail_count, n_compared, lc, sc, ec, n, r;
  usr_row_t rows[7];

  usr_serial uut (.REF_CLK_I(clk), .NRST_I(nrst), .LINK_CLK_I(lclk),
    .CFG_I(cfg), .CTL_I(ctl), .SLEEP_MODE_I(slp), .RXD_I(rxd),
    .TXD_O(txd), .TXD_OE_O(txd_oe), .TRANSFER_CLOCK_PIN_O(transfer_clock_pin),
    .TRANSFER_CLOCK_PIN_OE_O(xck_oe), .LINE_DRIVER_ENABLE_OUT_O(lde),
    .STAT_O(st), .RX_IRQ_O(irq), .PORT_CLK_REQ_O(creq));
  usr_peer peer (.sclk_i(transfer_clock_pin), .phase_i(cfg.sync_phase_select),
    .lsb_first_i(cfg.sync_bit_order_select), .rxd_o(rxd));

  // Port clock at 40 MHz and an unrelated 48 ns standby clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #24 lclk = ~lclk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic pulse(input usr_ctl_t c);
    @(posedge clk);
    ctl <= c;
    @(posedge clk);
    ctl <= '0;
  endtask
  task automatic clocks(input int k);
    repeat (k) @(posedge clk);
  endtask
  // A bounded wait on the clock request; running out ends the run.
  task automatic wait_req(input logic v, input string nm);
    int k;
    for (k = 0; k < 200 && creq !== v; k++) @(posedge clk);
    if (k == 200) begin
      $display("mismatch %s expected %b seen timeout", nm, v);
      fail_count++;
      close_out();
    end
    chk(nm, 8'(v), 8'(creq));
  endtask

  // Two cycles of reset; the standby side settles a few cycles later.
  initial begin
    nrst = 1'b0;
    slp = 2'h0;
    ctl = '0;
    cfg = '0;
    cfg.tx_enable = 1'b1;
    cfg.rx_enable = 1'b1;
    fail_count = 0;
    n_compared = 0;
    rows = '{'{1'b0, 400.0, 8'hA5, 1'b1}, '{1'b0, 408.0, 8'h3C, 1'b1},
      '{1'b0, 392.0, 8'hC3, 1'b1}, '{1'b1, 200.0, 8'h5A, 1'b1},
      '{1'b1, 203.0, 8'h0F, 1'b1}, '{1'b1, 197.0, 8'hF0, 1'b1},
      '{1'b0, 400.0, 8'h81, 1'b0}};
    clocks(2);
    nrst <= 1'b1;
    clocks(6);
    #1;
    chk("reset pins", 8'h0C, {4'h0, txd, st.dre, transfer_clock_pin, creq});
    chk("reset flags", 8'h00, {4'h0, st.txc, st.receive_complete_flag,
      st.start_detected_flag, irq});
    // Receive at rate ratios inside the tolerated span, then a bad stop.
    foreach (rows[i]) begin
      @(posedge clk);
      cfg.double_speed_select <= rows[i].dbl;
      clocks(2);
      peer.send(rows[i].d, rows[i].bt, rows[i].stp);
      clocks(4);
      chk("rx data", rows[i].d, st.rx_data);
      chk("rx done", 8'h01, 8'(st.receive_complete_flag));
      chk("frame err", 8'(!rows[i].stp), 8'(st.frame_error));
      pulse(rd_p);
    end
    // Transmit in each driver mode and time the driver enable.
    for (int m = 0; m < 3; m++) begin
      @(posedge clk);
      cfg.line_driver_mode <= 2'(m);
      pulse('{tx_write: 1'b1, tx_data: 8'h96, default: '0});
      lc = -1;
      sc = -1;
      ec = -1;
      got = '0;
      for (int c = 0; c < 300; c++) begin
        @(posedge clk);
        #1;
        if (lde === 1'b1 && lc < 0) lc = c;
        if (txd === 1'b0 && sc < 0) sc = c;
        if (sc >= 0 && (c - sc) % 16 == 8 && c - sc > 16 && c - sc < 144)
          got[(c - sc) / 16 - 1] = txd;
        if (lc >= 0 && lde !== 1'b1 && ec < 0) ec = c;
      end
      chk("tx byte", 8'h96, got);
      chk("txc", 8'h01, 8'(st.txc));
      if (m == 0) chk("lde off", 8'h00, 8'(lc >= 0));
      else begin
        chk("guard", 8'h10, 8'(sc - lc));
        chk("lde span", 8'hA0, 8'(ec - sc));
      end
      chk("txd drive", 8'(m != 2), 8'(txd_oe));
      pulse(clr_p);
    end
    // Start detection in standby, a false start, then the active state.
    @(posedge clk);
    cfg.start_detect_enable <= 1'b1;
    cfg.start_int_enable <= 1'b1;
    slp <= 2'h2;
    clocks(10);
    fork
      peer.send(8'h3C, 400.0, 1'b1);
      wait_req(1'b1, "wake request");
    join
    clocks(4);
    chk("start irq", 8'h03, {6'h00, st.start_detected_flag, irq});
    wait_req(1'b0, "request drop");
    pulse(clr_p);
    clocks(2);
    chk("irq clear", 8'h00, 8'(irq));
    fork
      peer.glitch(150.0);
      wait_req(1'b1, "false start request");
    join
    wait_req(1'b0, "false start release");
    clocks(30);
    chk("no frame", 8'h00, 8'(st.receive_complete_flag));
    pulse(clr_p);
    slp <= 2'h0;
    hi = 1'b0;
    clocks(10);
    fork
      peer.send(8'h55, 400.0, 1'b1);
      repeat (200) begin
        @(posedge clk);
        if (creq !== 1'b0) hi = 1'b1;
      end
    join
    chk("active no wake", 8'h00, 8'(hi));
    chk("active flags", 8'h02, {6'h00, st.receive_complete_flag,
      st.start_detected_flag});
    pulse(clr_p);
    // Synchronous master in all phase and order settings.
    cfg.start_detect_enable <= 1'b0;
    cfg.sync_mode <= 1'b1;
    cfg.line_driver_mode <= 2'h0;
    cfg.baud_div <= 16'h0003;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      cfg.sync_phase_select <= k[0];
      cfg.sync_bit_order_select <= k[1];
      clocks(2);
      peer.load(8'hC6 ^ 8'(k));
      pulse('{tx_write: 1'b1, tx_data: 8'h3A + 8'(k), default: '0});
      n = 0;
      r = 0;
      prv = 1'b0;
      got = '0;
      ptx = txd;
      // A slave takes the bit that stood on the line before its edge.
      repeat (120) begin
        @(posedge clk);
        #1;
        if (transfer_clock_pin !== prv && transfer_clock_pin === !k[0] && n < 8) begin
          got[k[1] ? n : 7 - n] = ptx;
          n++;
        end
        if (transfer_clock_pin !== prv && transfer_clock_pin === 1'b1) r++;
        prv = transfer_clock_pin;
        ptx = txd;
      end
      chk("mosi", 8'h3A + 8'(k), got);
      chk("rises", 8'h08, 8'(r));
      chk("miso", 8'hC6 ^ 8'(k), st.rx_data);
      chk("sync flags", 8'h0E, {4'h0, txd_oe, xck_oe,
        st.receive_complete_flag,
        st.frame_error});
      pulse(rd_p);
    end
    close_out();
  end
endmodule // tb_usart_spi_line_driver_mode_startdetect
